// *** hdl/battery_monitor_defs.svh ***
// constants for the battery monitor register map
// Operation
// - groups are byte-wide and read lowest byte first; 12-bit pairs span three bytes
// - config byte 0 holds pin status, pin controls, polling, ten-cell, duty code
// - cell bytes 15 to 17 are refused while ten-cell mode is set
// - flag bytes hold under and over flags per cell, four cells a byte
// - cells 11 and 12 flags read zero in ten-cell mode
// - temperature group packs three readings, revision and thermal shutdown bit
// - packet check byte returns the CRC over data bytes just read
// - duty code selects comparator off, period, and reference power-down
// - measure-mode pin low forces the duty code to five
// - cell voltage fields read all ones while a conversion runs
// - a set cell mask stops its comparisons and clears its flags
// - threshold is the 8-bit field times sixteen cell-value steps
`ifndef BATTERY_MONITOR_DEFS_SVH
`define BATTERY_MONITOR_DEFS_SVH

// group byte counts
`define CFG_BYTES 5'h06
`define CV_BYTES 5'h12
`define CV_TEN_LIMIT 5'h0F
`define FLG_BYTES 5'h03
`define TMP_BYTES 5'h05
`define PEC_BYTES 5'h01

// configuration and temperature byte indices
`define CFG_IDX0 5'h00
`define CFG_IDX1 5'h01
`define CFG_IDX2 5'h02
`define CFG_IDX3 5'h03
`define CFG_IDX4 5'h04
`define CFG_IDX5 5'h05
`define TMP_IDX_INT 5'h03
`define TMP_IDX_LAST 5'h04

// reset values: pull-downs off, everything else clear
`define CFG0_RESET 7'h60
`define CFG_BYTE_RESET 8'h00

// duty code encodings
`define DUTY_STANDBY 3'h0
`define DUTY_OFF 3'h1
`define DUTY_P13 3'h2
`define DUTY_P130 3'h3
`define DUTY_P500 3'h4
`define DUTY_LP130 3'h5
`define DUTY_LP500 3'h6
`define DUTY_LP2000 3'h7
`define DUTY_FORCED 3'h5

// comparison periods
`define SYS_CLK_KHZ 50000
`define CMP_P13_MS 13
`define CMP_P130_MS 130
`define CMP_P500_MS 500
`define CMP_P2000_MS 2000
`define TIMER_W 27

// conversion busy pattern and threshold scaling
`define CV_BUSY_VALUE 12'hFFF
`define THR_SHIFT_PAD 4'h0

// packet check and revision
`define CRC_POLY_DEF 8'h07
`define CRC_SEED_DEF 8'h41
`define REVISION_DEF 3'h1

`endif

// *** hdl/battery_monitor_pkg.sv ***
// types shared by the battery monitor files
`default_nettype none
package battery_monitor_pkg;
  typedef enum logic [2:0] {
    GRP_CFG = 3'h0,
    GRP_CV = 3'h1,
    GRP_FLG = 3'h2,
    GRP_TMP = 3'h3,
    GRP_PEC = 3'h4
  } group_t;
endpackage : battery_monitor_pkg
`default_nettype wire

// *** hdl/cell_limit.sv ***
// per-cell undervoltage and overvoltage flag pair
`include "battery_monitor_defs.svh"
`default_nettype none
module cell_limit (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [11:0] cell_value, // latest conversion result
  input wire logic [7:0] under_thr, // undervoltage threshold field
  input wire logic [7:0] over_thr, // overvoltage threshold field
  input wire logic mask, // cell interrupt mask
  input wire logic force_zero, // cell not present in ten-cell mode
  input wire logic update, // comparison result strobe
  output logic under_q, // undervoltage flag
  output logic over_q // overvoltage flag
);

  logic [11:0] under_lim;
  logic [11:0] over_lim;
  logic clear;

  // thresholds scaled to cell steps
  assign under_lim = {under_thr, `THR_SHIFT_PAD};
  assign over_lim = {over_thr, `THR_SHIFT_PAD};
  assign clear = mask | force_zero;

  // masked cells skip comparisons and hold their flags clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n || clear) begin
      under_q <= 1'b0;
      over_q <= 1'b0;
    end else if (update) begin
      under_q <= cell_value < under_lim;
      over_q <= cell_value > over_lim;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  mask_clears_a: assert property (mask |=> !under_q && !over_q)
    else $error("masked cell kept a flag");
  under_cmp_a: assert property (
    update && !clear |=> under_q == ($past(cell_value) < $past(under_lim)))
    else $error("undervoltage flag disagrees with threshold");

endmodule : cell_limit
`default_nettype wire

// *** hdl/battery_monitor_regs.sv ***
// register groups, flag logic and comparator timing of the monitor
`include "battery_monitor_defs.svh"
`default_nettype none
module battery_monitor_regs #(
  parameter int unsigned CMP_P13_CYC = `CMP_P13_MS * `SYS_CLK_KHZ,
  parameter int unsigned CMP_P130_CYC = `CMP_P130_MS * `SYS_CLK_KHZ,
  parameter int unsigned CMP_P500_CYC = `CMP_P500_MS * `SYS_CLK_KHZ,
  parameter int unsigned CMP_P2000_CYC = `CMP_P2000_MS * `SYS_CLK_KHZ,
  parameter logic [7:0] CRC_POLY = `CRC_POLY_DEF, // packet check polynomial
  parameter logic [7:0] CRC_SEED = `CRC_SEED_DEF, // packet check seed
  parameter logic [2:0] REVISION = `REVISION_DEF // arbitrary value
) (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [2:0] acc_group, // group selected by the command
  input wire logic [4:0] acc_index, // byte within the group
  input wire logic rd_stb, // read one byte
  input wire logic wr_stb, // write one configuration byte
  input wire logic [7:0] wr_data, // byte to write
  input wire logic crc_init, // start of a read packet
  output logic [7:0] rd_data_q, // byte read
  output logic rd_valid_q, // read answered
  output logic rd_refused_q, // read refused
  input wire logic [143:0] cell_values, // cell 1 in the low twelve bits
  input wire logic conv_busy, // conversion in progress
  input wire logic cmp_result_stb, // fresh results for comparison
  input wire logic [11:0] ext_temp1, // external temperature 1
  input wire logic [11:0] ext_temp2, // external temperature 2
  input wire logic [11:0] int_temp, // internal temperature
  input wire logic thermal_event, // thermal shutdown occurred
  input wire logic measure_mode_pin_n, // measure-mode pin
  input wire logic watchdog_pin, // watchdog pin level
  input wire logic [1:0] gpio_pin, // general pin levels
  output logic [11:0] discharge_en_q, // discharge switch enables
  output logic [1:0] gpio_oe_n_q, // pin pulled low while low
  output logic level_poll_q, // level polling selected
  output logic ten_cell_q, // ten-cell mode
  output logic [2:0] duty_code_q, // effective duty code
  output logic standby_q, // standby mode
  output logic vref_down_q, // reference off between measurements
  output logic cmp_tick_q, // start a comparison cycle
  output logic [11:0] under_flags, // undervoltage flags
  output logic [11:0] over_flags // overvoltage flags
);

  // refuse a zero 13, 130 or 500 ms period and a 2000 ms period too wide for the timer; a zero period would wrap the reload to all ones
  if (CMP_P13_CYC < 1 || CMP_P130_CYC < 1 || CMP_P500_CYC < 1 ||
      CMP_P2000_CYC >= (1 << `TIMER_W)) begin : g_bad_period
    $error("comparison period out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic mm_low;
  logic wdt_s;
  logic [1:0] gpio_s;

  // two flops before anything looks at a pin
  always_ff @(posedge sys_clk) begin
    pin_meta_q <= {measure_mode_pin_n, watchdog_pin, gpio_pin};
    pin_sync_q <= pin_meta_q;
  end

  assign mm_low = !pin_sync_q[3];
  assign wdt_s = pin_sync_q[2];
  assign gpio_s = pin_sync_q[1:0];

  ////////////////////////////////////////////////////////////////////////
  // configuration group

  logic [6:0] cfg0_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] cfg3_q;
  logic [7:0] uv_q;
  logic [7:0] ov_q;
  logic cfg_wr;
  logic [11:0] mask_bits;
  logic [2:0] duty_d;

  assign cfg_wr = wr_stb && acc_group == battery_monitor_pkg::GRP_CFG;

  // watchdog bit is read only, so only bits 6..0 are stored
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg0_q <= `CFG0_RESET;
      cfg1_q <= `CFG_BYTE_RESET;
      cfg2_q <= `CFG_BYTE_RESET;
      cfg3_q <= `CFG_BYTE_RESET;
      uv_q <= `CFG_BYTE_RESET;
      ov_q <= `CFG_BYTE_RESET;
    end else if (cfg_wr) begin
      case (acc_index)
        `CFG_IDX0: cfg0_q <= wr_data[6:0];
        `CFG_IDX1: cfg1_q <= wr_data;
        `CFG_IDX2: cfg2_q <= wr_data;
        `CFG_IDX3: cfg3_q <= wr_data;
        `CFG_IDX4: uv_q <= wr_data;
        `CFG_IDX5: ov_q <= wr_data;
        default: cfg1_q <= cfg1_q;
      endcase
    end
  end

  // pin low overrides whatever the host wrote
  assign duty_d = mm_low ? `DUTY_FORCED : cfg0_q[2:0];

  assign discharge_en_q = {cfg2_q[3:0], cfg1_q};
  assign mask_bits = {cfg3_q, cfg2_q[7:4]};
  assign gpio_oe_n_q = cfg0_q[6:5];
  assign level_poll_q = cfg0_q[4];
  assign ten_cell_q = cfg0_q[3];

  ////////////////////////////////////////////////////////////////////////
  // duty code decode and comparison timer

  logic [`TIMER_W-1:0] period_sel;
  logic [`TIMER_W-1:0] cmp_cnt_q;
  logic cmp_on;

  assign cmp_on = duty_code_q != `DUTY_STANDBY && duty_code_q != `DUTY_OFF;
  assign period_sel =
    (duty_code_q == `DUTY_P13) ? `TIMER_W'(CMP_P13_CYC - 1) :
    (duty_code_q == `DUTY_P130 || duty_code_q == `DUTY_LP130) ?
      `TIMER_W'(CMP_P130_CYC - 1) :
    (duty_code_q == `DUTY_P500 || duty_code_q == `DUTY_LP500) ?
      `TIMER_W'(CMP_P500_CYC - 1) :
    `TIMER_W'(CMP_P2000_CYC - 1);

  // timer rests at its reload value while the comparator is off
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      duty_code_q <= `DUTY_STANDBY;
      standby_q <= 1'b1;
      vref_down_q <= 1'b1;
      cmp_tick_q <= 1'b0;
      cmp_cnt_q <= '0;
    end else begin
      duty_code_q <= duty_d;
      standby_q <= duty_d == `DUTY_STANDBY;
      vref_down_q <= duty_d == `DUTY_STANDBY || duty_d >= `DUTY_LP130;
      cmp_tick_q <= cmp_on && cmp_cnt_q == '0;
      cmp_cnt_q <= (!cmp_on || cmp_cnt_q == '0) ? period_sel :
                   cmp_cnt_q - `TIMER_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-cell flags

  logic [11:0] cell_v [12];
  logic cmp_update;

  assign cmp_update = cmp_result_stb && cmp_on;

  for (genvar c = 0; c < 12; c++) begin : g_cell
    assign cell_v[c] = cell_values[c*12 +: 12];
    cell_limit u_limit (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .cell_value(cell_v[c]),
      .under_thr(uv_q),
      .over_thr(ov_q),
      .mask(mask_bits[c]),
      .force_zero(ten_cell_q && c >= 10),
      .update(cmp_update),
      .under_q(under_flags[c]),
      .over_q(over_flags[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  function automatic logic [7:0] pair_byte(
    input logic [11:0] a, input logic [11:0] b, input logic [1:0] j);
    logic [7:0] r;
    r = a[7:0];
    if (j == 2'h1) r = {b[3:0], a[11:8]};
    if (j == 2'h2) r = b[11:4];
    return r;
  endfunction : pair_byte

  function automatic logic [7:0] crc_byte(
    input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int k = 0; k < 8; k++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  logic [2:0] pair_idx;
  logic [1:0] pair_pos;
  logic [11:0] cv_a;
  logic [11:0] cv_b;
  logic [7:0] cfg_byte;
  logic [7:0] cv_byte;
  logic [7:0] flg_byte;
  logic [7:0] tmp_byte;
  logic [7:0] sel_byte;
  logic [11:0] under_rd;
  logic [11:0] over_rd;
  logic [23:0] flag_pack;
  logic idx_ok;
  logic rd_ok;
  logic thermal_shutdown_indicator_q;
  logic [7:0] crc_q;
  logic tmp_last_rd;

  assign pair_idx = 3'(acc_index / 5'h03);
  assign pair_pos = 2'(acc_index % 5'h03);
  // busy conversion reads as all ones
  assign cv_a = conv_busy ? `CV_BUSY_VALUE : cell_v[{pair_idx, 1'b0}];
  assign cv_b = conv_busy ? `CV_BUSY_VALUE : cell_v[{pair_idx, 1'b1}];
  assign cv_byte = pair_byte(cv_a, cv_b, pair_pos);

  assign cfg_byte =
    (acc_index == `CFG_IDX0) ? {wdt_s, gpio_s, cfg0_q[4:3], duty_code_q} :
    (acc_index == `CFG_IDX1) ? cfg1_q :
    (acc_index == `CFG_IDX2) ? cfg2_q :
    (acc_index == `CFG_IDX3) ? cfg3_q :
    (acc_index == `CFG_IDX4) ? uv_q : ov_q;

  // gate again here so a mode change shows on the very next read
  assign under_rd = under_flags & ~{ten_cell_q, ten_cell_q, 10'h000};
  assign over_rd = over_flags & ~{ten_cell_q, ten_cell_q, 10'h000};
  for (genvar c = 0; c < 12; c++) begin : g_flag
    assign flag_pack[2*c] = under_rd[c];
    assign flag_pack[2*c+1] = over_rd[c];
  end
  assign flg_byte = flag_pack[{acc_index[1:0], 3'h0} +: 8];

  assign tmp_byte =
    (acc_index == `TMP_IDX_LAST) ? {REVISION, thermal_shutdown_indicator_q, int_temp[11:8]} :
    (acc_index == `TMP_IDX_INT) ? int_temp[7:0] :
    pair_byte(ext_temp1, ext_temp2, pair_pos);

  assign idx_ok =
    (acc_group == battery_monitor_pkg::GRP_CFG) ? acc_index < `CFG_BYTES :
    (acc_group == battery_monitor_pkg::GRP_CV) ? acc_index < `CV_BYTES &&
      !(ten_cell_q && acc_index >= `CV_TEN_LIMIT) :
    (acc_group == battery_monitor_pkg::GRP_FLG) ? acc_index < `FLG_BYTES :
    (acc_group == battery_monitor_pkg::GRP_TMP) ? acc_index < `TMP_BYTES :
    (acc_group == battery_monitor_pkg::GRP_PEC) ? acc_index < `PEC_BYTES :
    1'b0;
  assign rd_ok = rd_stb && idx_ok;

  assign sel_byte =
    (acc_group == battery_monitor_pkg::GRP_CFG) ? cfg_byte :
    (acc_group == battery_monitor_pkg::GRP_CV) ? cv_byte :
    (acc_group == battery_monitor_pkg::GRP_FLG) ? flg_byte :
    (acc_group == battery_monitor_pkg::GRP_TMP) ? tmp_byte : crc_q;

  assign tmp_last_rd = rd_ok && acc_group == battery_monitor_pkg::GRP_TMP &&
                       acc_index == `TMP_IDX_LAST;

  // answer one cycle after the strobe; check covers data bytes only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      rd_refused_q <= 1'b0;
      crc_q <= CRC_SEED;
      thermal_shutdown_indicator_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_ok;
      rd_refused_q <= rd_stb && !idx_ok;
      if (rd_ok) rd_data_q <= sel_byte;
      if (crc_init) crc_q <= CRC_SEED;
      else if (rd_ok && acc_group != battery_monitor_pkg::GRP_PEC)
        crc_q <= crc_byte(crc_q, sel_byte);
      // a new event wins over the clear on read
      if (thermal_event) thermal_shutdown_indicator_q <= 1'b1;
      else if (tmp_last_rd) thermal_shutdown_indicator_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence cv_high_req;
    rd_stb && acc_group == battery_monitor_pkg::GRP_CV &&
      acc_index >= `CV_TEN_LIMIT && acc_index < `CV_BYTES;
  endsequence

  sequence rd_answer;
    (rd_valid_q ^ rd_refused_q) ##1 1'b1;
  endsequence

  rd_one_answer_a: assert property (rd_stb |=> rd_answer)
    else $error("read not answered exactly once");
  ten_refuse_a: assert property ((ten_cell_q and cv_high_req)
    |=> rd_refused_q && !rd_valid_q)
    else $error("high cell byte read in ten-cell mode");
  uv_write_a: assert property (
    cfg_wr && acc_index == `CFG_IDX4 |=> uv_q == $past(wr_data))
    else $error("undervoltage threshold not stored");
  duty_force_a: assert property (mm_low |=> duty_code_q == `DUTY_FORCED)
    else $error("measure-mode pin did not force duty code");
  busy_read_a: assert property (
    rd_stb && conv_busy && acc_group == battery_monitor_pkg::GRP_CV &&
    acc_index == `CFG_IDX0 |=> rd_data_q == 8'hFF)
    else $error("busy cell byte not all ones");
  ten_flags_a: assert property (
    ten_cell_q && $past(ten_cell_q) |-> under_flags[11:10] == 2'h0 &&
    over_flags[11:10] == 2'h0)
    else $error("absent cell flag set in ten-cell mode");
  tick_off_a: assert property (!cmp_on ##1 !cmp_on |-> !cmp_tick_q)
    else $error("comparison tick while comparator off");
  pec_read_a: assert property (
    rd_stb && acc_group == battery_monitor_pkg::GRP_PEC &&
    acc_index == `CFG_IDX0 |=> rd_data_q == $past(crc_q))
    else $error("packet check byte mismatch");
  thermal_shutdown_indicator_set_a: assert property (thermal_event |=> thermal_shutdown_indicator_q [*1])
    else $error("thermal shutdown event lost");
  // answers only ever follow a strobe, so a stray pulse is caught too
  no_stray_answer_a: assert property (
    !rd_stb |=> !rd_valid_q && !rd_refused_q)
    else $error("read answer without a strobe");
  refused_hold_a: assert property (
    rd_stb && !idx_ok && !crc_init |=>
    $stable(rd_data_q) && $stable(crc_q))
    else $error("refused read changed the held byte or check");
  flag_gate_a: assert property (
    rd_stb && ten_cell_q && acc_group == battery_monitor_pkg::GRP_FLG &&
    acc_index == `CFG_IDX2 |=> rd_data_q[7:4] == 4'h0)
    else $error("absent cell flag read back in ten-cell mode");
  crc_reseed_a: assert property (crc_init |=> crc_q == CRC_SEED)
    else $error("packet check not reseeded");
  thermal_shutdown_indicator_clear_a: assert property (
    tmp_last_rd && !thermal_event |=> !thermal_shutdown_indicator_q)
    else $error("thermal shutdown bit not cleared on read");

endmodule : battery_monitor_regs
`default_nettype wire

// *** testbench/meas_front.sv ***
// conversion front end model that feeds cell results to the monitor
`default_nettype none
module meas_front (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic start, // begin a conversion
  output logic [143:0] cell_values, // cell 1 in the low bits
  output logic conv_busy, // conversion running
  output logic cmp_result_stb // fresh results pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy_cnt_q;
  // results land only when the conversion ends, never mid-way
  always_ff @(posedge sys_clk) begin
    cmp_result_stb <= 1'b0;
    if (!reset_n) begin
      busy_cnt_q <= 4'h0;
      conv_busy <= 1'b0;
      cell_values <= '0;
    end else if (start) begin
      busy_cnt_q <= 4'h8;
      conv_busy <= 1'b1;
    end else if (busy_cnt_q == 4'h1) begin
      busy_cnt_q <= 4'h0;
      conv_busy <= 1'b0;
      cmp_result_stb <= 1'b1;
      for (int k = 0; k < 12; k++) begin
        cell_values[12*k +: 12] <= 12'((k + 1) * 'h111 + 1);
      end
    end else if (busy_cnt_q != 4'h0) begin
      busy_cnt_q <= busy_cnt_q - 4'h1;
    end
  end
endmodule : meas_front
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the battery monitor register map
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] G_CFG = battery_monitor_pkg::GRP_CFG;
  localparam logic [2:0] G_CV = battery_monitor_pkg::GRP_CV;
  localparam logic [2:0] G_FLG = battery_monitor_pkg::GRP_FLG;
  localparam logic [2:0] G_TMP = battery_monitor_pkg::GRP_TMP;
  localparam logic [2:0] G_PEC = battery_monitor_pkg::GRP_PEC;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] acc_group = 3'h0;
  logic [4:0] acc_index = 5'h00;
  logic rd_stb = 1'b0;
  logic wr_stb = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic crc_init = 1'b0;
  logic start = 1'b0;
  logic [11:0] ext_temp1 = 12'hABC;
  logic [11:0] ext_temp2 = 12'h123;
  logic [11:0] int_temp = 12'h456;
  logic thermal_event = 1'b0;
  logic measure_mode_pin_n = 1'b1;
  logic watchdog_pin = 1'b1;
  logic [1:0] gpio_pin = 2'h1;
  wire [7:0] rd_data_q;
  wire rd_valid_q, rd_refused_q, conv_busy, cmp_result_stb;
  wire [143:0] cell_values;
  wire [11:0] discharge_en_q, under_flags, over_flags;
  wire [1:0] gpio_oe_n_q;
  wire level_poll_q, ten_cell_q, standby_q, vref_down_q, cmp_tick_q;
  wire [2:0] duty_code_q;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] got;
  logic [7:0] crc_exp;
  int ptab[8] = '{0, 0, 20, 40, 60, 40, 60, 80};
  logic [7:0] tmpb[5] = '{8'hBC, 8'h3A, 8'h12, 8'h56, 8'h34};

  always #10 sys_clk = ~sys_clk;

  battery_monitor_regs #(.CMP_P13_CYC(20), .CMP_P130_CYC(40),
    .CMP_P500_CYC(60), .CMP_P2000_CYC(80)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .acc_group(acc_group),
    .acc_index(acc_index), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wr_data(wr_data), .crc_init(crc_init), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_refused_q(rd_refused_q),
    .cell_values(cell_values), .conv_busy(conv_busy),
    .cmp_result_stb(cmp_result_stb), .ext_temp1(ext_temp1),
    .ext_temp2(ext_temp2), .int_temp(int_temp),
    .thermal_event(thermal_event),
    .measure_mode_pin_n(measure_mode_pin_n),
    .watchdog_pin(watchdog_pin), .gpio_pin(gpio_pin),
    .discharge_en_q(discharge_en_q), .gpio_oe_n_q(gpio_oe_n_q),
    .level_poll_q(level_poll_q), .ten_cell_q(ten_cell_q),
    .duty_code_q(duty_code_q), .standby_q(standby_q),
    .vref_down_q(vref_down_q), .cmp_tick_q(cmp_tick_q),
    .under_flags(under_flags), .over_flags(over_flags));

  meas_front front (.sys_clk(sys_clk), .reset_n(reset_n),
    .start(start), .cell_values(cell_values), .conv_busy(conv_busy),
    .cmp_result_stb(cmp_result_stb));

  ////////////////////////////////////////////////////////////////////
  // expected values and shared tasks
  function automatic logic [11:0] cv(input int k);
    return 12'(k * 'h111 + 1);
  endfunction : cv

  // byte b of the cell group, two 12-bit values per three bytes
  function automatic logic [7:0] cvb(input int b);
    logic [11:0] a;
    logic [11:0] c;
    a = cv(2 * (b / 3) + 1);
    c = cv(2 * (b / 3) + 2);
    case (b % 3)
      0: return a[7:0];
      1: return {c[3:0], a[11:8]};
      default: return c[11:4];
    endcase
  endfunction : cvb

  // crc-8, msb first, no reflection, no final xor
  function automatic logic [7:0] fold(input logic [7:0] c,
                                      input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction : fold

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // one read strobe; answer is taken one edge later
  task automatic rd(input logic [2:0] g, input int i);
    @(posedge sys_clk);
    #1;
    acc_group = g;
    acc_index = 5'(i);
    rd_stb = 1'b1;
    cyc(1);
    rd_stb = 1'b0;
    got = rd_data_q;
  endtask : rd

  task automatic rc(input logic [2:0] g, input int i, input logic [7:0] e);
    rd(g, i);
    chk({rd_valid_q, rd_refused_q, got}, {2'b10, e});
  endtask : rc

  // a refused read must leave the held byte alone
  task automatic rr(input logic [2:0] g, input int i);
    logic [7:0] prev;
    prev = got;
    rd(g, i);
    chk({rd_valid_q, rd_refused_q, got}, {2'b01, prev});
  endtask : rr

  task automatic wr(input logic [2:0] g, input int i, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    acc_group = g;
    acc_index = 5'(i);
    wr_data = d;
    wr_stb = 1'b1;
    cyc(1);
    wr_stb = 1'b0;
  endtask : wr

  // interval between two comparison ticks, bounded wait
  task automatic per(input int e);
    int n;
    n = 0;
    while (cmp_tick_q !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (cmp_tick_q !== 1'b1 && n < 300);
    chk(12'(n), 12'(e));
  endtask : per

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////
  // run takes about a thousand cycles; the limit is far beyond that
  initial begin
    #(20 * 20000);
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    int n;
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    cyc(3); // pin synchronisers settle
    rc(G_CFG, 0, 8'hA0);
    for (int i = 1; i < 6; i++) rc(G_CFG, i, 8'h00);
    chk({gpio_oe_n_q, standby_q, duty_code_q}, 6'h38);
    wr(G_CFG, 1, 8'hA5);
    wr(G_CFG, 2, 8'h3C);
    wr(G_CFG, 3, 8'h00);
    wr(G_CFG, 4, 8'h40);
    wr(G_CFG, 5, 8'h80);
    wr(G_CFG, 0, 8'h62);
    cyc(2);
    chk(discharge_en_q, 12'hCA5);
    rc(G_CFG, 0, 8'hA2);
    rc(G_CFG, 2, 8'h3C);
    rc(G_CFG, 5, 8'h80);
    // conversion: busy pattern first, then fresh results and flags
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    rc(G_CV, 0, 8'hFF);
    rc(G_CV, 1, 8'hFF);
    n = 0;
    while (conv_busy === 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    chk(12'(n < 50), 12'h001);
    cyc(3);
    for (int b = 0; b < 18; b++) rc(G_CV, b, cvb(b));
    chk(under_flags, 12'h004);
    chk(over_flags, 12'hF80);
    rc(G_FLG, 0, 8'h10);
    rc(G_FLG, 1, 8'h80);
    rc(G_FLG, 2, 8'hAA);
    wr(G_CFG, 0, 8'h6A);
    chk({ten_cell_q, level_poll_q}, 2'b10);
    rc(G_CV, 14, cvb(14));
    for (int b = 15; b < 18; b++) rr(G_CV, b);
    rc(G_FLG, 2, 8'h0A);
    wr(G_CFG, 3, 8'hFF);
    cyc(2);
    chk(over_flags, 12'h000);
    // every duty code, with the tick period where the comparator runs
    for (int c = 0; c < 8; c++) begin
      wr(G_CFG, 0, 8'h60 | 8'(c));
      cyc(3);
      chk({standby_q, vref_down_q, duty_code_q},
          {c == 0, c == 0 || c > 4, 3'(c)});
      rc(G_CFG, 0, 8'hA0 | 8'(c));
      if (c > 1) per(ptab[c]);
    end
    // pull-downs on, level polling, and pins read back at new levels
    wr(G_CFG, 0, 8'h10);
    watchdog_pin = 1'b0;
    gpio_pin = 2'h2;
    cyc(3);
    chk({gpio_oe_n_q, level_poll_q, ten_cell_q}, 12'h002);
    rc(G_CFG, 0, 8'h50);
    watchdog_pin = 1'b1;
    gpio_pin = 2'h1;
    wr(G_CFG, 0, 8'h60);
    measure_mode_pin_n = 1'b0;
    cyc(4);
    chk(duty_code_q, 12'h005);
    rc(G_CFG, 0, 8'hA5);
    measure_mode_pin_n = 1'b1;
    // thermal event and packet check over the temperature group
    thermal_event = 1'b1;
    crc_init = 1'b1;
    cyc(1);
    thermal_event = 1'b0;
    crc_init = 1'b0;
    crc_exp = 8'h41;
    for (int b = 0; b < 5; b++) begin
      rc(G_TMP, b, tmpb[b]);
      crc_exp = fold(crc_exp, tmpb[b]);
    end
    rc(G_PEC, 0, crc_exp);
    rc(G_TMP, 4, 8'h24);
    rr(3'h5, 0);
    rr(G_CFG, 6);
    wr(G_CV, 0, 8'h00);
    rc(G_CV, 0, cvb(0));
    end_of_test();
  end
endmodule : tb
`default_nettype wire
